// >>> logic/tsfmt_pkg.sv
// Purpose: Shared constants and carriers for the stream packet formatter
// Assumes: Wishbone classic register bus, 32-bit data, byte addresses
// Notes:   Register offsets are byte addresses of aligned words
package tsfmt_pkg;

    // Register map
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_SEED       = 8'h04;
    localparam logic [7:0] REG_STATUS     = 8'h08;
    localparam logic [7:0] REG_STAT_CLR   = 8'h0c;
    localparam logic [7:0] REG_ENABLE     = 8'h10;
    localparam logic [7:0] REG_TIME       = 8'h14;
    localparam logic [7:0] REG_WR_THR0    = 8'h20;
    localparam logic [7:0] REG_RD_THR     = 8'h40;
    localparam logic [7:0] REG_CMP0       = 8'h60;

    // Control field positions
    localparam int CTRL_RX_MODE_LSB = 0;
    localparam int CTRL_SEED_SEL    = 2;
    localparam int CTRL_NONTS       = 3;
    localparam int CTRL_LEN_LSB     = 4;
    localparam int CTRL_STAMP_EN    = 7;
    localparam int CTRL_BIG64       = 8;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEED_RESET = 32'h0000_0000;

    // Receive stamp modes
    typedef enum logic [1:0] {
        TSF_STAMP_KEEP    = 2'b00,
        TSF_STAMP_ADD     = 2'b01,
        TSF_STAMP_REPLACE = 2'b10
    } tsf_stamp_e;

    // Packet and unit sizes
    localparam logic [8:0] TS_BODY_LEN  = 9'd188;
    localparam logic [8:0] TS_UNIT_LEN  = 9'd192;
    localparam logic [8:0] NTS_UNIT_LEN = 9'd256;
    localparam logic [8:0] NTS_BASE_LEN = 9'd200;
    localparam logic [3:0] STAMP_BYTES  = 4'd4;
    localparam logic [2:0] LEN_CODE_MAX = 3'h7;

    // Status bit positions: 0..7 write rings, 8 read ring, 9..16 compares
    localparam int ST_RD_RING = 8;
    localparam int ST_CMP_LSB = 9;
    localparam int ST_RX_ERR  = 17;
    localparam int ST_MAP     = 18;
    localparam int ST_ASSOC   = 19;
    localparam int ST_PICGRP  = 20;
    localparam int ST_BOUND   = 21;
    localparam int ST_WIDTH   = 22;

    // Stream events from the filter logic
    typedef struct packed {
        logic rx_err;
        logic map_found;
        logic assoc_found;
        logic pic_group;
        logic boundary;
    } tsf_evt_s;

    // One 64-bit memory write
    typedef struct packed {
        logic        valid;
        logic [63:0] data;
        logic        last;
    } tsf_mem_s;

endpackage : tsfmt_pkg

// >>> logic/tsfmt_core.sv
// Purpose: Packet framer: stamps, sizes and packs stream bytes into 64-bit words
// Assumes: Serial stream bits arrive on a link clock slower than clk_i
// Notes:   Ring addresses and stream events come from neighbouring logic
`timescale 1ns/100ps

// Behaviour
// - Mode 0 stores 192-byte packet unchanged
// - Mode 1 prepends arrival stamp to 188 bytes
// - Mode 2 overwrites carried stamp with own
// - Seed select 0: first stamp from packet
// - Seed select 1: first stamp from seed
// - Non-TS lengths 200 to 256 step 8
// - Stamping allowed for all lengths but 256
// - TS mode moves 192-byte units
// - Non-TS mode moves 256-byte units
// - Memory data path is 64 bits
// - 32-bit mode fills words from MSB
// - 64-bit mode fills from LSB lane
// - Bits within byte stay MSB first
// - Flags for eight write rings, read ring
// - Write ring flag after packet DMA done
// - Read ring flag at threshold address
// - Eight time compares set own flags
// - Packet error sets its flag
// - Map and association tables set flags
// - Picture group start sets flag
// - Boundary word sets boundary flag
// - Emulation suspend input accepted
module tsfmt_core
    import tsfmt_pkg::*;
(
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial link
    input  wire logic        link_clk_i,
    input  wire logic        link_data_i,
    input  wire logic        link_start_i,
    // Neighbouring logic
    input  wire tsf_evt_s    evt_i,
    input  wire logic [7:0]  wr_dma_done_i,
    input  wire logic [7:0]  wr_hit_i,
    input  wire logic [31:0] rd_addr_i,
    input  wire logic        emu_suspend_i,
    // Memory side
    output tsf_mem_s         mem_o,
    output logic             irq_o
);

    function automatic logic [7:0] lane_of(input logic big64, input logic [2:0] idx);
        // Byte lane within the 64-bit word for the idx-th stream byte
        if (big64) begin
            lane_of = 8'(idx);
        end else begin
            lane_of = {5'h0, idx[2], ~idx[1:0]};
        end
    endfunction : lane_of

    function automatic logic [4:0] stamp_shift(input logic [1:0] idx);
        // Bit offset of the idx-th stamp byte, high byte first
        stamp_shift = 5'd24 - {idx, 3'h0};
    endfunction : stamp_shift

    function automatic logic is_cmp_adr(input logic [7:0] adr);
        // Compare entries fill one aligned 32-byte block
        is_cmp_adr = (adr[7:5] == REG_CMP0[7:5]);
    endfunction : is_cmp_adr

    logic [31:0] ctrl_ff;
    logic [31:0] seed_ff;
    logic [ST_WIDTH-1:0] stat_ff;
    logic [ST_WIDTH-1:0] en_ff;
    logic [31:0] time_ff;
    logic [31:0] rd_thr_ff;
    logic [31:0] cmp_ff [8];
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        susp_ff;

    // Link synchronisers
    logic [2:0]  clk_sync_ff;
    logic [1:0]  dat_sync_ff;
    logic [1:0]  st_sync_ff;

    tsf_stamp_e  rx_mode;
    logic        nonts;
    logic        stamp_en;
    logic        big64;
    logic [2:0]  len_code;
    logic [8:0]  body_len;
    logic [8:0]  unit_len;
    logic        stamp_ins;
    logic        stamp_ovr;

    assign rx_mode  = tsf_stamp_e'(ctrl_ff[CTRL_RX_MODE_LSB +: 2]);
    assign nonts    = ctrl_ff[CTRL_NONTS];
    assign len_code = ctrl_ff[CTRL_LEN_LSB +: 3];
    assign big64    = ctrl_ff[CTRL_BIG64];
    // Code 7 with stamping is not allowed; stamping is then dropped
    assign stamp_en = ctrl_ff[CTRL_STAMP_EN] && (len_code != LEN_CODE_MAX);

    always_comb begin
        body_len  = TS_UNIT_LEN;
        unit_len  = TS_UNIT_LEN;
        stamp_ins = 1'b0;
        stamp_ovr = 1'b0;
        if (nonts) begin
            body_len  = NTS_BASE_LEN + {3'h0, len_code, 3'h0};
            unit_len  = NTS_UNIT_LEN;
            stamp_ins = stamp_en;
        end else begin
            case (rx_mode)
                TSF_STAMP_ADD: begin
                    body_len  = TS_BODY_LEN;
                    stamp_ins = 1'b1;
                end
                TSF_STAMP_REPLACE: stamp_ovr = 1'b1;
                default: ;
            endcase
        end
    end

    // Two flops before any logic; third only delays for edge detect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sync_ff <= 3'h0;
            dat_sync_ff <= 2'h0;
            st_sync_ff  <= 2'h0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[1:0], link_clk_i};
            dat_sync_ff <= {dat_sync_ff[0], link_data_i};
            st_sync_ff  <= {st_sync_ff[0], link_start_i};
        end
    end

    logic bit_stb;
    assign bit_stb = clk_sync_ff[1] && !clk_sync_ff[2];

    // Arrival time counter, frozen while the CPU is halted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            time_ff <= 32'h0;
            susp_ff <= 1'b0;
        end else begin
            susp_ff <= emu_suspend_i;
            if (!susp_ff) begin
                time_ff <= time_ff + 32'h1;
            end
        end
    end

    // Byte assembly, MSB first
    logic [7:0] shift_ff;
    logic [2:0] bitc_ff;
    logic       byte_stb;
    logic [7:0] byte_val;
    logic       pkt_start;

    assign byte_val  = {shift_ff[6:0], dat_sync_ff[1]};
    assign byte_stb  = bit_stb && (bitc_ff == 3'h7);
    assign pkt_start = bit_stb && st_sync_ff[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_ff <= 8'h0;
            bitc_ff  <= 3'h0;
        end else if (bit_stb) begin
            shift_ff <= byte_val;
            bitc_ff  <= st_sync_ff[1] ? 3'h1 : bitc_ff + 3'h1;
        end
    end

    // Packet sequencing and packing
    logic [8:0]  pos_ff;
    logic        first_ff;
    logic [31:0] stamp_ff;
    logic [63:0] word_ff;
    logic [2:0]  wbyte_ff;
    logic        in_pkt_ff;
    logic        pad_ff;
    logic        seeded_ff;
    logic [31:0] tx_ref_ff;
    logic [7:0]  put_byte;
    logic        put_stb;
    logic [1:0]  sidx;
    logic [8:0]  stamp_len;
    logic [8:0]  pos_inc;
    logic        pkt_end;
    logic        unit_end;

    assign sidx      = pos_ff[1:0];
    assign stamp_len = stamp_ins ? 9'(STAMP_BYTES) : 9'h0;
    assign pos_inc   = pos_ff + 9'h1;
    // Payload ends after the body plus any inserted stamp
    assign pkt_end   = in_pkt_ff && (pos_inc == body_len + stamp_len);
    assign unit_end  = (pos_inc == unit_len);

    always_comb begin
        put_byte = byte_val;
        put_stb  = 1'b0;
        if (in_pkt_ff && byte_stb) begin
            put_stb = 1'b1;
            if (stamp_ovr && pos_ff < 9'(STAMP_BYTES)) begin
                put_byte = stamp_ff[stamp_shift(sidx) +: 8];
            end
        end else if (pad_ff) begin
            put_stb  = 1'b1;
            put_byte = 8'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_ff    <= 9'h0;
            stamp_ff  <= 32'h0;
            word_ff   <= 64'h0;
            wbyte_ff  <= 3'h0;
            in_pkt_ff <= 1'b0;
            pad_ff    <= 1'b0;
            mem_o     <= '0;
        end else begin
            mem_o.valid <= 1'b0;
            mem_o.last  <= 1'b0;
            if (pkt_start && !in_pkt_ff && !pad_ff) begin
                in_pkt_ff <= 1'b1;
                stamp_ff  <= time_ff;
                pos_ff    <= stamp_len;
                wbyte_ff  <= 3'h0;
                word_ff   <= 64'h0;
                if (stamp_ins) begin
                    // Stamp bytes go first, high byte first
                    for (int i = 0; i < 4; i++) begin
                        word_ff[8*lane_of(big64, 3'(i)) +: 8] <= time_ff[8*(3-i) +: 8];
                    end
                    wbyte_ff <= 3'h4;
                end
            end else if (put_stb) begin
                word_ff[8*lane_of(big64, wbyte_ff) +: 8] <= put_byte;
                wbyte_ff <= wbyte_ff + 3'h1;
                pos_ff   <= pos_inc;
                if (pkt_end) begin
                    in_pkt_ff <= 1'b0;
                    pad_ff    <= !unit_end;
                end
                if (pad_ff && unit_end) begin
                    pad_ff <= 1'b0;
                end
                if (wbyte_ff == 3'h7) begin
                    mem_o.valid <= 1'b1;
                    mem_o.data  <= word_ff;
                    mem_o.data[8*lane_of(big64, wbyte_ff) +: 8] <= put_byte;
                    mem_o.last  <= unit_end;
                    word_ff     <= 64'h0;
                end
            end
        end
    end

    // Transmit timing reference for the first packet
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seeded_ff <= 1'b0;
            tx_ref_ff <= 32'h0;
        end else if (!seeded_ff) begin
            if (ctrl_ff[CTRL_SEED_SEL]) begin
                tx_ref_ff <= seed_ff;
                seeded_ff <= 1'b1;
            end else if (in_pkt_ff && byte_stb && pos_ff < 9'(STAMP_BYTES)) begin
                tx_ref_ff[stamp_shift(sidx) +: 8] <= byte_val;
                seeded_ff <= (pos_ff == 9'(STAMP_BYTES) - 9'h1);
            end
        end
    end

    // Status flags: set wins over clear
    logic [ST_WIDTH-1:0] set_vec;
    logic [ST_WIDTH-1:0] clr_vec;
    logic                wr_hit;

    // A request counts once, on the edge that raises ack
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;

    always_comb begin
        set_vec = '0;
        set_vec[7:0] = wr_hit_i & wr_dma_done_i;
        set_vec[ST_RD_RING] = (rd_addr_i == rd_thr_ff);
        for (int i = 0; i < 8; i++) begin
            set_vec[ST_CMP_LSB + i] = (time_ff == cmp_ff[i]);
        end
        set_vec[ST_RX_ERR] = evt_i.rx_err;
        set_vec[ST_MAP]    = evt_i.map_found;
        set_vec[ST_ASSOC]  = evt_i.assoc_found;
        set_vec[ST_PICGRP] = evt_i.pic_group;
        set_vec[ST_BOUND]  = evt_i.boundary;
        clr_vec = '0;
        if (wr_hit && wb_adr_i == REG_STAT_CLR) begin
            clr_vec = wb_dat_i[ST_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~clr_vec) | set_vec;
        end
    end

    // Level request; flags stay set until software clears them
    assign irq_o = |(stat_ff & en_ff);

    // Register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff   <= CTRL_RESET;
            seed_ff   <= SEED_RESET;
            en_ff     <= '0;
            rd_thr_ff <= 32'h0;
            for (int i = 0; i < 8; i++) begin
                cmp_ff[i] <= 32'hffff_ffff;
            end
        end else if (wr_hit && wb_sel_i == 4'hf) begin
            case (wb_adr_i)
                REG_CTRL:   ctrl_ff   <= wb_dat_i;
                REG_SEED:   seed_ff   <= wb_dat_i;
                REG_ENABLE: en_ff     <= wb_dat_i[ST_WIDTH-1:0];
                REG_RD_THR: rd_thr_ff <= wb_dat_i;
                default: begin
                    if (is_cmp_adr(wb_adr_i)) begin
                        cmp_ff[wb_adr_i[4:2]] <= wb_dat_i;
                    end
                end
            endcase
        end
    end

    // Read mux and ack
    // Read data is registered so it stands with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
            case (wb_adr_i)
                REG_CTRL:   dat_ff <= ctrl_ff;
                REG_SEED:   dat_ff <= seed_ff;
                REG_STATUS: dat_ff <= 32'(stat_ff);
                REG_ENABLE: dat_ff <= 32'(en_ff);
                REG_TIME:   dat_ff <= time_ff;
                REG_WR_THR0: dat_ff <= tx_ref_ff;
                REG_RD_THR: dat_ff <= rd_thr_ff;
                default: begin
                    if (is_cmp_adr(wb_adr_i)) begin
                        dat_ff <= cmp_ff[wb_adr_i[4:2]];
                    end else begin
                        dat_ff <= 32'h0;
                    end
                end
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

endmodule : tsfmt_core

// >>> tb/tsfmt_assertions.sv
// Purpose: Port checks for the packet framer
// Assumes: One clock domain, synchronous reset
// Notes:   Bound into every tsfmt_core instance
`timescale 1ns/100ps
module tsfmt_checker
    import tsfmt_pkg::*;
(
    // System
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Memory and interrupt
    input wire tsf_mem_s    mem_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_quiet7;
        !mem_o.valid [*7];
    endsequence
    sequence s_quiet8;
        !mem_o.valid [*8];
    endsequence

    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i[7]) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_last_word: assert property (mem_o.last |-> mem_o.valid)
        else $error("last without word");
    a_word_gap: assert property (mem_o.valid |=> s_quiet7)
        else $error("words too close");
    a_unit_gap: assert property (mem_o.valid && mem_o.last |=> s_quiet8)
        else $error("word right after unit end");
    a_irq_hold: assert property (irq_o && !(wb_cyc_i && wb_we_i) |=> irq_o)
        else $error("irq dropped without write");
endmodule : tsfmt_checker

bind tsfmt_core tsfmt_checker tsfmt_checker_inst (.*);

// >>> tb/tsfmt_link_host.sv
// Purpose: Serial stream host sending one packet of counting bytes
// Assumes: Link clock of 160 ns, standing low between packets
// Notes:   Data line inverts after a packet so stale bits never look valid
`timescale 1ns/100ps
module tsfmt_link_host (
    // Serial link
    output logic link_clk_o,
    output logic link_data_o,
    output logic link_start_o
);
    initial begin
        link_clk_o = 1'b0;
        link_data_o = 1'b0;
        link_start_o = 1'b0;
    end

    // Byte k carries the value k
    task automatic send(input int n);
        logic [7:0] b;
        #3;
        for (int k = 0; k < 8 * n; k++) begin
            b = 8'(k / 8);
            link_data_o = b[7 - k % 8];
            link_start_o = (k == 0);
            #80 link_clk_o = 1'b1;
            #80 link_clk_o = 1'b0;
        end
        link_start_o = 1'b0;
        link_data_o = ~link_data_o;
    endtask : send
endmodule : tsfmt_link_host

// >>> tb/tsfmt_core_tb.sv
// Purpose: Self-checking bench for the packet framer
// Assumes: Link host model drives the serial side
// Notes:   Three full units keep the run near 93k cycles
`timescale 1ns/100ps
module tsfmt_core_tb;
    import tsfmt_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        lclk;
    logic        ldat;
    logic        lstart;
    tsf_evt_s    evt = '0;
    logic [7:0]  done = 8'h00;
    logic [7:0]  hit = 8'h00;
    logic [31:0] raddr = 32'h1234_5670;
    logic        emu = 1'b0;
    tsf_mem_s    mem;
    logic        irq;
    logic [63:0] words[$];
    int          last_at;
    int          error_cnt = 0;
    int          compares = 0;
    logic [31:0] q;
    logic [31:0] q2;

    always #4 clk_i = ~clk_i;

    tsfmt_core tsfmt_core_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .link_clk_i(lclk), .link_data_i(ldat), .link_start_i(lstart), .evt_i(evt),
        .wr_dma_done_i(done), .wr_hit_i(hit), .rd_addr_i(raddr), .emu_suspend_i(emu),
        .mem_o(mem), .irq_o(irq)
    );
    tsfmt_link_host tsfmt_link_host_inst (
        .link_clk_o(lclk), .link_data_o(ldat), .link_start_o(lstart)
    );

    always @(posedge clk_i) begin
        if (mem.valid) begin
            words.push_back(mem.data);
            if (mem.last) last_at = words.size();
        end
    end

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (ack !== 1'b1) chk("ack", 1, 0);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
        wb(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask : rd

    // Expected word at unit byte k; payload byte p holds p, padding is zero
    function automatic logic [63:0] ew(input int k, input logic m64, input int n, input int off);
        logic [63:0] r;
        int p;
        r = '0;
        for (int j = 0; j < 8; j++) begin
            p = k + j - off;
            if (p >= 0 && p < n) r[8 * (m64 ? j : (j < 4 ? 3 - j : 11 - j)) +: 8] = 8'(p);
        end
        return r;
    endfunction : ew

    task automatic unit(input logic [31:0] c, input int n, input int off, input int nw,
                        input int f);
        int t;
        t = 0;
        wb(1'b1, REG_CTRL, c);
        words.delete();
        last_at = 0;
        tsfmt_link_host_inst.send(n);
        while (words.size() < nw && t < 1000) begin
            @(posedge clk_i);
            t++;
        end
        chk("word count", nw, words.size());
        chk("last index", nw, last_at);
        for (int i = f; i < nw; i++) chk("word", ew(8 * i, c[CTRL_BIG64], n, off), words[i]);
        $display("unit %h done", c);
    endtask : unit

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(REG_CTRL, CTRL_RESET, "ctrl reset");
        rd(REG_SEED, SEED_RESET, "seed reset");
        rd(REG_STATUS, 32'h0, "status reset");
        rd(8'h80, 32'h0, "unmapped");
        wb(1'b1, REG_SEED, 32'h1357_9bdf);
        wb(1'b1, REG_CTRL, 32'h4);
        rd(8'h20, 32'h1357_9bdf, "seed ref");
        wb(1'b1, REG_ENABLE, 32'h0);
        evt <= tsf_evt_s'(5'h10);
        @(posedge clk_i);
        evt <= '0;
        rd(REG_STATUS, 32'h1 << ST_RX_ERR, "masked flag");
        chk("masked irq", 0, irq);
        wb(1'b1, REG_STAT_CLR, 32'h1 << ST_RX_ERR);
        wb(1'b1, REG_ENABLE, 32'h3f_ffff);
        for (int b = 0; b < 5; b++) begin
            evt <= tsf_evt_s'(5'h10 >> b);
            @(posedge clk_i);
            evt <= '0;
            rd(REG_STATUS, 32'h1 << (ST_RX_ERR + b), "event");
            chk("irq set", 1, irq);
            wb(1'b1, REG_STAT_CLR, 32'h1 << (ST_RX_ERR + b));
            @(posedge clk_i);
            chk("irq clear", 0, irq);
        end
        hit <= 8'h08;
        @(posedge clk_i);
        hit <= 8'h00;
        rd(REG_STATUS, 32'h0, "hit alone");
        {hit, done} <= 16'h0808;
        @(posedge clk_i);
        {hit, done} <= 16'h0;
        rd(REG_STATUS, 32'h8, "write ring");
        wb(1'b1, REG_STAT_CLR, 32'h8);
        wb(1'b1, REG_RD_THR, 32'h100);
        raddr <= 32'h100;
        @(posedge clk_i);
        raddr <= 32'h1234_5670;
        rd(REG_STATUS, 32'h1 << ST_RD_RING, "read ring");
        wb(1'b1, REG_STAT_CLR, 32'h1 << ST_RD_RING);
        emu <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b0, REG_TIME, 32'h0);
        q2 = q;
        wb(1'b0, REG_TIME, 32'h0);
        chk("frozen time", q2, q);
        emu <= 1'b0;
        wb(1'b1, REG_CMP0, q + 32'd40);
        wb(1'b0, REG_STATUS, 32'h0);
        for (int i = 0; i < 100 && q[ST_CMP_LSB] !== 1'b1; i++) wb(1'b0, REG_STATUS, 32'h0);
        chk("compare flag", 1, q[ST_CMP_LSB]);
        $display("register tests done");
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("irq after reset", 0, irq);
        rd(REG_CTRL, CTRL_RESET, "ctrl after reset");
        rd(REG_WR_THR0, 32'h0, "ref after reset");
        $display("reset tests done");
        unit(32'h0, 192, 0, 24, 0);
        rd(REG_WR_THR0, 32'h0001_0203, "packet ref");
        unit(32'h101, 188, 4, 24, 1);
        unit(32'h8, 200, 0, 32, 0);
        finish_test();
    end

    initial begin
        #790_000;
        error_cnt++;
        finish_test();
    end
endmodule : tsfmt_core_tb
